// ### bench/oscdc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module oscdc_monitor (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic [2:0]  current_source_sel,
  input wire logic        secondary_osc_enable,
  input wire logic [1:0]  pll_postscaler,
  input wire logic [8:0]  pll_multiplier,
  input wire logic [5:0]  rc_trim,
  input wire logic [2:0]  periph_ratio_log2,
  input wire logic        pll_mode
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // =====
  // Read-back of holes and status.
  ctl_holes_a: assert property ($past(rd) && $past(addr) == 4'h0 |-> (rdata & 16'h8854) == 16'h0000)
    else $error("control hole bits not zero");
  div_hole_a: assert property ($past(rd) && $past(addr) == 4'h1 |-> rdata[5] == 1'b0)
    else $error("divisor hole bit not zero");
  fbd_holes_a: assert property ($past(rd) && $past(addr) == 4'h2 |-> rdata[15:9] == 7'h00)
    else $error("feedback hole bits not zero");
  cur_field_a: assert property ($past(rd) && $past(addr) == 4'h0 |->
    rdata[14:12] == $past(current_source_sel))
    else $error("current field differs from active source");
  // =====
  // Outputs tied to their causes.
  pll_decode_a: assert property ($stable(current_source_sel) |->
    pll_mode == (current_source_sel == 3'h1 || current_source_sel == 3'h3))
    else $error("pll mode does not match source");
  post_legal_a: assert property (pll_postscaler != 2'b10)
    else $error("reserved postscaler code applied");
  sec_write_a: assert property ($changed(secondary_osc_enable) |->
    $past(wr) && $past(addr) == 4'h0 && secondary_osc_enable == $past(wdata[1]))
    else $error("secondary enable moved without a write");
  mult_write_a: assert property ($changed(pll_multiplier) |->
    $past(wr) && $past(addr) == 4'h2 && pll_multiplier == $past(wdata[8:0]))
    else $error("multiplier moved without a write");
  trim_write_a: assert property ($changed(rc_trim) |->
    $past(wr) && $past(addr) == 4'h3 && rc_trim == $past(wdata[5:0]))
    else $error("trim moved without a write");
  // A ratio step must be followed by at least eight steady cycles, never a short pulse.
  ratio_clean_a: assert property ($changed(periph_ratio_log2) |=>
    $stable(periph_ratio_log2)[*8])
    else $error("ratio changed off a clean boundary");
endmodule // oscdc_monitor
bind oscdc_top oscdc_monitor oscdc_monitor_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .current_source_sel(current_source_sel), .secondary_osc_enable(secondary_osc_enable),
  .pll_postscaler(pll_postscaler), .pll_multiplier(pll_multiplier), .rc_trim(rc_trim),
  .periph_ratio_log2(periph_ratio_log2), .pll_mode(pll_mode));
`default_nettype wire

// ### bench/test_oscdc_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_oscdc_top;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic [2:0]  src_cfg = 3'h0;
  logic [1:0]  pri_cfg = 2'h0;
  logic        lock_cfg = 1'b0;
  logic        pll_lk = 1'b0;
  logic        fail = 1'b0;
  logic        irq = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic [2:0]  cur, rcps, ratio, ns;
  logic [1:0]  pri, post;
  logic        sec, pmode;
  logic [4:0]  pre;
  logic [8:0]  mul;
  logic [5:0]  trim;
  logic [15:0] v, w, e, g;
  logic [15:0] m [1:3];
  logic [7:0]  h;
  logic [3:0]  a;
  integer      seed = 32;
  int          bad_count = 0;
  int          compares = 0;

  always #10 sys_clk = ~sys_clk;

  oscdc_top oscdc_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .initial_source_cfg(src_cfg), .primary_submode_cfg(pri_cfg), .clock_lock_cfg(lock_cfg),
    .switch_enable_cfg(1'b1), .pll_locked(pll_lk), .failsafe_monitor(fail),
    .source_ready(1'b1), .irq_event(irq), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .current_source_sel(cur), .primary_submode(pri),
    .secondary_osc_enable(sec), .rc_postscaler(rcps), .pll_postscaler(post),
    .pll_prescaler(pre), .pll_multiplier(mul), .rc_trim(trim),
    .periph_ratio_log2(ratio), .pll_mode(pmode));

  // =====
  // Bus tasks and checks.
  task automatic end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t saw %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rchk(input logic [3:0] ad, input logic [15:0] exp);
    @(posedge sys_clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic ctl_wr(input logic [15:0] d);
    bus_wr(4'h0, oscdc_pkg::OSCDC_UNLOCK_KEY1);
    bus_wr(4'h0, oscdc_pkg::OSCDC_UNLOCK_KEY2);
    bus_wr(4'h0, d);
  endtask
  task automatic pulse_irq;
    @(posedge sys_clk);
    irq <= 1'b1;
    @(posedge sys_clk);
    irq <= 1'b0;
  endtask
  task automatic wait_for(input bit on_ratio, input logic [2:0] x);
    int n;
    n = 0;
    #1;
    while ((on_ratio ? ratio : cur) !== x) begin
      @(posedge sys_clk);
      #1 n++;
      if (n > 600) begin
        bad_count++;
        end_sim();
      end
    end
  endtask
  function automatic logic [15:0] model(input logic [3:0] ad, input logic [15:0] d,
                                        input logic [15:0] old);
    logic [15:0] r;
    r = (ad == 4'h1) ? (d & 16'hffdf) : (ad == 4'h2) ? (d & 16'h01ff) : (d & 16'h003f);
    if (ad == 4'h1 && d[7:6] == 2'b10) r[7:6] = old[7:6];
    return r;
  endfunction

  // =====
  // Main sequence.
  initial begin
    src_cfg = 3'($random(seed));
    pri_cfg = 2'($random(seed));
    h = {1'b0, src_cfg, 1'b0, src_cfg};
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk({13'h0, cur}, {13'h0, src_cfg});
    chk({14'h0, pri}, {14'h0, pri_cfg});
    chk({15'h0, pmode}, {15'h0, src_cfg == 3'h1 || src_cfg == 3'h3});
    rchk(4'h0, {h, 8'h00});
    rchk(4'h1, 16'h3040);
    rchk(4'h2, 16'h0030);
    rchk(4'h3, 16'h0000);
    rchk(4'h9, 16'h0000);
    m[1] = 16'h3040;
    m[2] = 16'h0030;
    m[3] = 16'h0000;
    for (int i = 0; i < 15; i++) begin
      a = 4'(i % 3 + 1);
      w = (i < 3) ? 16'hffff : (i < 6) ? 16'h0080 : 16'($random(seed));
      e = model(a, w, m[a]);
      m[a] = e;
      bus_wr(a, w);
      #1 g = (a == 4'h1) ? {9'h0, post, pre} : (a == 4'h2) ? {7'h0, mul} : {10'h0, trim};
      v = (a == 4'h1) ? {9'h0, e[7:6], e[4:0]} : (a == 4'h2) ? {7'h0, e[8:0]} : e;
      chk(g, v);
      rchk(a, e);
    end
    // With the clock enable low a write must leave the trim register as it was.
    clk_en <= 1'b0;
    bus_wr(4'h3, ~m[3]);
    clk_en <= 1'b1;
    rchk(4'h3, m[3]);
    bus_wr(4'h0, 16'h0002);
    rchk(4'h0, {h, 8'h00});
    ctl_wr({h, 8'h0a});
    rchk(4'h0, {h, 8'h02});
    chk({15'h0, sec}, 16'h0001);
    fail <= 1'b1;
    repeat (4) @(posedge sys_clk);
    fail <= 1'b0;
    rchk(4'h0, {h, 8'h0a});
    ctl_wr({h, 8'h02});
    rchk(4'h0, {h, 8'h02});
    ns = (src_cfg == 3'h5) ? 3'h0 : 3'h5;
    ctl_wr({5'h0, ns, 8'h03});
    wait_for(1'b0, ns);
    rchk(4'h0, {1'b0, ns, 1'b0, ns, 8'h02});
    @(posedge sys_clk);
    pll_lk <= 1'b1;
    ctl_wr(16'h0103);
    wait_for(1'b0, 3'h1);
    rchk(4'h0, 16'h1122);
    chk({15'h0, pmode}, 16'h0001);
    // A switch to the source already running must finish at once.
    ctl_wr(16'h0103);
    rchk(4'h0, 16'h1122);
    // Park the ratio at zero first, so the step to five carries the new postscaler with it.
    bus_wr(4'h1, 16'h0000);
    wait_for(1'b1, 3'h0);
    bus_wr(4'h1, 16'h5d00);
    wait_for(1'b1, 3'h5);
    chk({13'h0, rcps}, 16'h0005);
    pulse_irq();
    rchk(4'h1, 16'h5d00);
    bus_wr(4'h1, 16'hdd00);
    pulse_irq();
    rchk(4'h1, 16'hd500);
    wait_for(1'b1, 3'h0);
    @(posedge sys_clk);
    lock_cfg <= 1'b1;
    ctl_wr(16'h0182);
    ctl_wr(16'h0083);
    rchk(4'h0, 16'h11a2);
    bus_wr(4'h2, 16'h0005);
    rchk(4'h2, m[2]);
    @(posedge sys_clk);
    src_cfg <= 3'h7;
    sys_rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rchk(4'h0, 16'h7700);
    end_sim();
  end
endmodule // test_oscdc_top
`default_nettype wire

// ### verilog/oscdc_pkg.sv
// ==========================================================================
// How it works
// - Power-on clock mode comes from the three-bit initial source configuration.
// - Erased configuration gives internal RC divide-by-N mode.
// - Primary submode field picks high-speed, standard crystal or external clock.
// - Current source field, bits 14..12, is read-only, same encoding.
// - Requested source field, bits 10..8, is writable, reset from configuration.
// - Freeze bit plus lock configuration freezes clock and PLL settings.
// - PLL lock bit reads one when locked and the requested source uses the PLL.
// - Clock fail bit set by monitor, cleared by software, never set.
// - Bit 1 enables the secondary oscillator, resets to zero.
// - Writing switch bit requests a switch; hardware clears it on completion.
// - Control register writes accepted only after the unlock sequence.
// - With recover-on-interrupt set, an interrupt clears reduction enable.
// - Reduction field divides instruction clock by two to the code.
// - Reduction enable applies the field; otherwise ratio is one to one.
// - RC postscaler divides by 1..64, or 256 for code 111.
// - PLL postscaler divides by 2, 4 or 8; code 10 reserved.
// - PLL prescaler divides by field value plus two.
// - PLL multiplier is field value plus two, reset gives 50.
// - Six-bit signed RC trim, resets to zero.
// - Unimplemented bits read as zero.
// - Instruction clock is oscillator or PLL output divided by two.
// - PLL output is input times multiplier over prescale times postscale.
// ==========================================================================
package oscdc_pkg;
  localparam logic [1:0] OSCDC_ADDR_OSC  = 2'h0;
  localparam logic [1:0] OSCDC_ADDR_DIV  = 2'h1;
  localparam logic [1:0] OSCDC_ADDR_FBD  = 2'h2;
  localparam logic [1:0] OSCDC_ADDR_TUN  = 2'h3;
  localparam int OSCDC_CURRENT_SOURCE_SEL_LSB  = 12;
  localparam int OSCDC_REQUESTED_SOURCE_SEL_LSB  = 8;
  localparam int OSCDC_FREEZE_BIT = 7;
  localparam int OSCDC_LOCK_BIT  = 5;
  localparam int OSCDC_CF_BIT    = 3;
  localparam int OSCDC_SECONDARY_OSC_BIT  = 1;
  localparam int OSCDC_SW_BIT    = 0;
  localparam int OSCDC_ROI_BIT   = 15;
  localparam int OSCDC_RED_LSB   = 12;
  localparam int OSCDC_REDEN_BIT = 11;
  localparam int OSCDC_RCPS_LSB  = 8;
  localparam int OSCDC_POST_LSB  = 6;
  localparam int OSCDC_PRE_LSB   = 0;
  localparam logic [2:0] OSCDC_RED_RST  = 3'h3;
  localparam logic [2:0] OSCDC_RCPS_RST = 3'h0;
  localparam logic [1:0] OSCDC_POST_RST = 2'h1;
  localparam logic [4:0] OSCDC_PRE_RST  = 5'h00;
  localparam logic [8:0] OSCDC_MUL_RST  = 9'h030;
  localparam logic [5:0] OSCDC_TRIM_RST = 6'h00;
  localparam logic [15:0] OSCDC_UNLOCK_KEY1 = 16'h0055;
  localparam logic [15:0] OSCDC_UNLOCK_KEY2 = 16'h00aa;
  localparam logic [2:0] OSCDC_UNLOCK_WIN = 3'h4;
  localparam logic [3:0] OSCDC_SWITCH_CYC = 4'ha;
  typedef enum logic [2:0] {
    OSCDC_SRC_FRC, OSCDC_SRC_INTERNAL_RC_WITH_PLL, OSCDC_SRC_PRI, OSCDC_SRC_PRIPLL,
    OSCDC_SRC_SEC, OSCDC_SRC_LOW_POWER_RC, OSCDC_SRC_FRC16, OSCDC_SRC_FRCN
  } oscdc_src_t;
endpackage

// ### verilog/oscdc_top.sv
`timescale 1ns/10ps
`default_nettype none
module oscdc_top (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [2:0]  initial_source_cfg,
  input  wire logic [1:0]  primary_submode_cfg,
  input  wire logic        clock_lock_cfg,
  input  wire logic        switch_enable_cfg,
  input  wire logic        pll_locked,
  input  wire logic        failsafe_monitor,
  input  wire logic        source_ready,
  input  wire logic        irq_event,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  output logic      [2:0]  current_source_sel,
  output logic      [1:0]  primary_submode,
  output logic             secondary_osc_enable,
  output logic      [2:0]  rc_postscaler,
  output logic      [1:0]  pll_postscaler,
  output logic      [4:0]  pll_prescaler,
  output logic      [8:0]  pll_multiplier,
  output logic      [5:0]  rc_trim,
  output logic      [2:0]  periph_ratio_log2,
  output logic             pll_mode
);
  // ==========================================================================
  // Decoders
  // ==========================================================================
  function automatic logic pll_source(input logic [2:0] src);
    return (src == oscdc_pkg::OSCDC_SRC_INTERNAL_RC_WITH_PLL) || (src == oscdc_pkg::OSCDC_SRC_PRIPLL);
  endfunction

  function automatic logic reg_hit(input logic [3:0] ad, input logic [1:0] sel);
    return ad == {2'h0, sel};
  endfunction

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       pll_lock_s;
  logic       fail_s;
  logic       ready_s;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else if (clk_en) begin
      sync1_reg <= {source_ready, failsafe_monitor, pll_locked};
      sync2_reg <= sync1_reg;
    end
  end
  assign pll_lock_s = sync2_reg[0];
  assign fail_s     = sync2_reg[1];
  assign ready_s    = sync2_reg[2];

  // ==========================================================================
  // Registers and unlock
  // ==========================================================================
  logic [2:0] cur_reg;
  logic [2:0] new_reg;
  logic       freeze_reg;
  logic       cf_reg;
  logic       secondary_osc_reg;
  logic       sw_reg;
  logic       roi_reg;
  logic [2:0] red_reg;
  logic       reden_reg;
  logic [2:0] rcps_reg;
  logic [1:0] post_reg;
  logic [4:0] pre_reg;
  logic [8:0] mul_reg;
  logic [5:0] trim_reg;
  logic [1:0] ulk_reg;
  logic [2:0] ulk_cnt_reg;
  logic       boot_reg;
  logic       frozen;
  logic       wr_osc;
  logic       wr_div;
  logic       wr_fbd;
  logic       wr_tun;
  logic       sw_done;
  logic       sw_valid;

  assign frozen = freeze_reg & clock_lock_cfg;
  assign wr_osc = wr & reg_hit(addr, oscdc_pkg::OSCDC_ADDR_OSC) & (ulk_reg == 2'h2);
  assign wr_div = wr & reg_hit(addr, oscdc_pkg::OSCDC_ADDR_DIV);
  assign wr_fbd = wr & reg_hit(addr, oscdc_pkg::OSCDC_ADDR_FBD) & ~frozen;
  assign wr_tun = wr & reg_hit(addr, oscdc_pkg::OSCDC_ADDR_TUN);

  // Two key writes to the control address open a short window for one write.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ulk_reg     <= 2'h0;
      ulk_cnt_reg <= 3'h0;
    end else if (clk_en) begin
      if (wr && reg_hit(addr, oscdc_pkg::OSCDC_ADDR_OSC) && ulk_reg == 2'h0
          && wdata == oscdc_pkg::OSCDC_UNLOCK_KEY1) begin
        ulk_reg     <= 2'h1;
        ulk_cnt_reg <= oscdc_pkg::OSCDC_UNLOCK_WIN;
      end else if (wr && reg_hit(addr, oscdc_pkg::OSCDC_ADDR_OSC) && ulk_reg == 2'h1
                   && wdata == oscdc_pkg::OSCDC_UNLOCK_KEY2) begin
        ulk_reg     <= 2'h2;
        ulk_cnt_reg <= oscdc_pkg::OSCDC_UNLOCK_WIN;
      end else if (wr && reg_hit(addr, oscdc_pkg::OSCDC_ADDR_OSC)) begin
        ulk_reg <= 2'h0;
      end else if (ulk_cnt_reg == 3'h0) begin
        ulk_reg <= 2'h0;
      end else begin
        ulk_cnt_reg <= ulk_cnt_reg - 3'h1;
      end
    end
  end

  // The strap is caught in the first enabled cycle after reset release.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      boot_reg <= 1'b1;
    end else if (clk_en) begin
      boot_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Control register
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cur_reg    <= 3'h7;
      new_reg    <= 3'h7;
      freeze_reg <= 1'b0;
      secondary_osc_reg   <= 1'b0;
    end else if (clk_en) begin
      if (boot_reg) begin
        cur_reg <= initial_source_cfg;
        new_reg <= initial_source_cfg;
      end else begin
        if (sw_done) begin
          cur_reg <= new_reg;
        end
        if (wr_osc && !frozen) begin
          new_reg <= wdata[oscdc_pkg::OSCDC_REQUESTED_SOURCE_SEL_LSB +: 3];
        end
        if (wr_osc) begin
          freeze_reg <= wdata[oscdc_pkg::OSCDC_FREEZE_BIT];
          secondary_osc_reg   <= wdata[oscdc_pkg::OSCDC_SECONDARY_OSC_BIT];
        end
      end
    end
  end

  // ==========================================================================
  // Clock switch sequencer
  // ==========================================================================
  typedef enum logic [1:0] {OSCDC_IDLE, OSCDC_WAIT, OSCDC_SETTLE} oscdc_sw_t;
  oscdc_sw_t  sw_state_reg;
  logic [3:0] settle_reg;
  logic       need_pll;

  assign need_pll = pll_source(new_reg);
  assign sw_valid = new_reg != cur_reg;
  assign sw_done  = (sw_state_reg == OSCDC_SETTLE) && (settle_reg == 4'h0);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sw_reg       <= 1'b0;
      sw_state_reg <= OSCDC_IDLE;
      settle_reg   <= 4'h0;
    end else if (clk_en) begin
      unique case (sw_state_reg)
        OSCDC_IDLE: begin
          if (wr_osc && !frozen && switch_enable_cfg && wdata[oscdc_pkg::OSCDC_SW_BIT]) begin
            sw_reg       <= 1'b1;
            sw_state_reg <= OSCDC_WAIT;
          end
        end
        OSCDC_WAIT: begin
          if (!sw_valid) begin
            sw_reg       <= 1'b0;
            sw_state_reg <= OSCDC_IDLE;
          end else if (ready_s && (!need_pll || pll_lock_s)) begin
            settle_reg   <= oscdc_pkg::OSCDC_SWITCH_CYC - 4'h1;
            sw_state_reg <= OSCDC_SETTLE;
          end
        end
        OSCDC_SETTLE: begin
          if (settle_reg == 4'h0) begin
            sw_reg       <= 1'b0;
            sw_state_reg <= OSCDC_IDLE;
          end else begin
            settle_reg <= settle_reg - 4'h1;
          end
        end
      endcase
    end
  end

  // A valid switch still waiting on a source that is not ready clears the fail flag; a fresh failure wins over any clear.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cf_reg <= 1'b0;
    end else if (clk_en) begin
      if (fail_s) begin
        cf_reg <= 1'b1;
      end else if ((wr_osc && !wdata[oscdc_pkg::OSCDC_CF_BIT])
                   || (sw_state_reg == OSCDC_WAIT && sw_valid && sw_reg
                       && settle_reg == 4'h0 && !ready_s)) begin
        cf_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Divisor, feedback and tuning registers
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      roi_reg   <= 1'b0;
      red_reg   <= oscdc_pkg::OSCDC_RED_RST;
      reden_reg <= 1'b0;
      rcps_reg  <= oscdc_pkg::OSCDC_RCPS_RST;
      post_reg  <= oscdc_pkg::OSCDC_POST_RST;
      pre_reg   <= oscdc_pkg::OSCDC_PRE_RST;
    end else if (clk_en) begin
      if (wr_div) begin
        roi_reg  <= wdata[oscdc_pkg::OSCDC_ROI_BIT];
        red_reg  <= wdata[oscdc_pkg::OSCDC_RED_LSB +: 3];
        rcps_reg <= wdata[oscdc_pkg::OSCDC_RCPS_LSB +: 3];
        if (!frozen) begin
          if (wdata[oscdc_pkg::OSCDC_POST_LSB +: 2] != 2'h2) begin
            post_reg <= wdata[oscdc_pkg::OSCDC_POST_LSB +: 2];
          end
          pre_reg <= wdata[oscdc_pkg::OSCDC_PRE_LSB +: 5];
        end
      end
      if (roi_reg && irq_event) begin
        reden_reg <= 1'b0;
      end else if (wr_div) begin
        reden_reg <= wdata[oscdc_pkg::OSCDC_REDEN_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mul_reg  <= oscdc_pkg::OSCDC_MUL_RST;
      trim_reg <= oscdc_pkg::OSCDC_TRIM_RST;
    end else if (clk_en) begin
      if (wr_fbd) begin
        mul_reg <= wdata[8:0];
      end
      if (wr_tun) begin
        trim_reg <= wdata[5:0];
      end
    end
  end

  // ==========================================================================
  // Clean-boundary ratio update
  // ==========================================================================
  // The ratio outputs change only when a free-running count wraps, so the
  // downstream divider never sees a truncated period.
  logic [7:0] phase_reg;
  logic [2:0] ratio_reg;
  logic [2:0] rcps_out_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_reg    <= 8'h00;
      ratio_reg    <= 3'h0;
      rcps_out_reg <= oscdc_pkg::OSCDC_RCPS_RST;
    end else if (clk_en) begin
      phase_reg <= phase_reg + 8'h01;
      if (phase_reg == 8'hff) begin
        ratio_reg    <= reden_reg ? red_reg : 3'h0;
        rcps_out_reg <= rcps_reg;
      end
    end
  end

  // ==========================================================================
  // Outputs and read port
  // ==========================================================================
  assign current_source_sel   = cur_reg;
  assign primary_submode      = primary_submode_cfg;
  assign secondary_osc_enable = secondary_osc_reg;
  assign rc_postscaler        = rcps_out_reg;
  assign pll_postscaler       = post_reg;
  assign pll_prescaler        = pre_reg;
  assign pll_multiplier       = mul_reg;
  assign rc_trim              = trim_reg;
  assign periph_ratio_log2    = ratio_reg;
  assign pll_mode             = pll_source(cur_reg);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      rdata <= 16'h0000;
      if (rd) begin
        unique case (addr)
          4'h0: rdata <= {1'b0, cur_reg, 1'b0, new_reg, freeze_reg, 1'b0,
                          pll_lock_s & need_pll, 1'b0, cf_reg, 1'b0, secondary_osc_reg, sw_reg};
          4'h1: rdata <= {roi_reg, red_reg, reden_reg, rcps_reg, post_reg, 1'b0, pre_reg};
          4'h2: rdata <= {7'h00, mul_reg};
          4'h3: rdata <= {10'h000, trim_reg};
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule // oscdc_top
`default_nettype wire
